// file: verilog/tag_ram_pkg.sv
// Purpose: shared types and constants of the pipelined cache tag memory
// Assumes: one rising-edge clock, synchronous active-high reset
// Notes: lanes are 9 bits wide, two lanes make one 18-bit word
package tag_ram_pkg;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int BURST_W = 2;
  localparam int HI_W = ADDR_W - BURST_W;
  localparam int DEPTH = 262144;
  localparam int LOW_LANE = 0;
  localparam int HIGH_LANE = 1;

  localparam logic [LANES-1:0] LANES_ALL = 2'h3;
  localparam logic [LANES-1:0] LANES_NONE = 2'h0;
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam logic [HI_W-1:0] ADDR_HI_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;

  typedef enum logic [1:0] {CYC_IDLE, CYC_READ, CYC_WRITE} cyc_t;

  // write controls as sampled at the pins, all active low
  typedef struct packed {
    logic all_bytes_write_n;
    logic byte_write_gate_n;
    logic high_byte_wr_n;
    logic low_byte_wr_n;
  } wr_ctl_t;

  // three chip enables, mixed polarity
  typedef struct packed {
    logic chip_en_n;
    logic chip_sel_depth_n;
    logic chip_sel_depth;
  } chip_sel_t;

  function automatic logic [LANES-1:0] lane_mask(input wr_ctl_t w);
    logic [LANES-1:0] m;
    m = LANES_NONE;
    if (!w.all_bytes_write_n) begin
      m = LANES_ALL;
    end else if (!w.byte_write_gate_n) begin
      m[LOW_LANE] = !w.low_byte_wr_n;
      m[HIGH_LANE] = !w.high_byte_wr_n;
    end
    return m;
  endfunction

  function automatic logic selected(input chip_sel_t c);
    return !c.chip_en_n && !c.chip_sel_depth_n && c.chip_sel_depth;
  endfunction

endpackage

// file: verilog/tag_array.sv
// Purpose: 256K x 18 storage with per-lane writes and registered read
// Assumes: read-first; a write returns the old word on rd_data
// Notes: no reset, contents are undefined until written
module tag_array
  import tag_ram_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // access
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [LANES-1:0] wr_lanes,
  input wire logic [DATA_W-1:0] wr_data,
  output logic [DATA_W-1:0] rd_data
);

  logic [DATA_W-1:0] mem [DEPTH];

  // self-timed write: done within the edge, nothing more from the host
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (wr_lanes[i]) begin
        mem[addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
      end
    end
    rd_data <= mem[addr];
  end

endmodule

// file: verilog/burst_seq.sv
// Purpose: two-bit burst sequencer over the lowest address bits
// Assumes: mode pin is static, sampled directly
// Notes: interleaved order is start xor count, linear wraps
module burst_seq
  import tag_ram_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic load,
  input wire logic [BURST_W-1:0] start,
  input wire logic advance,
  input wire logic linear,
  // burst address
  output logic [BURST_W-1:0] lo
);

  typedef struct packed {
    logic [BURST_W-1:0] start;
    logic [BURST_W-1:0] cnt;
  } seq_t;

  seq_t st_r;
  seq_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (load) begin
      st_nxt.start = start;
      st_nxt.cnt = BURST_RST;
    end else if (advance) begin
      st_nxt.cnt = st_r.cnt + BURST_STEP;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lo = linear ? st_r.start + st_r.cnt : st_r.start ^ st_r.cnt;

endmodule

// file: verilog/tag_ram.sv
// Purpose: synchronous pipelined tag memory with data comparator
// Assumes: all synchronous pins meet setup/hold to ref_clk
// Notes: output enables are asynchronous; match_oe comes straight from its pin, dq_oe also needs rd_vld
module tag_ram
  import tag_ram_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // address and strobes
  input wire logic [ADDR_W-1:0] addr,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic burst_mode,
  // chip enables
  input wire logic chip_en_n,
  input wire logic chip_sel_depth_n,
  input wire logic chip_sel_depth,
  // write controls
  input wire logic low_byte_wr_n,
  input wire logic high_byte_wr_n,
  input wire logic byte_write_gate_n,
  input wire logic all_bytes_write_n,
  // data path, one shared two-way bus
  input wire logic din_load_en_n,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic data_out_drive_n,
  // compare result, two-way style pin
  output logic match_out,
  output logic match_oe,
  input wire logic compare_out_drive_n
);

  typedef struct packed {
    logic [HI_W-1:0] addr_hi;
    cyc_t op;
    logic [LANES-1:0] lanes;
    logic [DATA_W-1:0] din;
    logic [DATA_W-1:0] cmp_din;
    logic rd_vld;
    logic match;
  } core_t;

  core_t st_r;
  core_t st_nxt;

  wr_ctl_t wr_ctl;
  chip_sel_t cs;
  logic [LANES-1:0] pin_lanes;
  logic cs_ok;
  logic proc_start;
  logic ctrl_start;
  logic addr_load;
  logic burst_step;
  logic [BURST_W-1:0] burst_lo;
  logic [ADDR_W-1:0] arr_addr;
  logic [DATA_W-1:0] arr_q;
  logic [LANES-1:0] arr_lanes;
  logic cmp_eq;

  assign wr_ctl = '{all_bytes_write_n, byte_write_gate_n,
                    high_byte_wr_n, low_byte_wr_n};
  assign cs = '{chip_en_n, chip_sel_depth_n, chip_sel_depth};
  assign pin_lanes = lane_mask(wr_ctl);
  assign cs_ok = selected(cs);

  // processor strobe is ignored unless the primary enable is low
  assign proc_start = !proc_addr_strobe_n && !chip_en_n;
  assign ctrl_start = !ctrl_addr_strobe_n && !proc_start;
  assign addr_load = proc_start || ctrl_start;
  assign burst_step = !addr_load && st_r.op != CYC_IDLE
                      && !burst_advance_n;

  burst_seq u_burst (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(addr_load),
    .start(addr[BURST_W-1:0]),
    .advance(burst_step),
    .linear(!burst_mode),
    .lo(burst_lo)
  );

  assign arr_addr = {st_r.addr_hi, burst_lo};
  // writes land one edge after the controls were taken
  assign arr_lanes = (st_r.op == CYC_WRITE) ? st_r.lanes
                                            : LANES_NONE;

  tag_array u_array (
    .ref_clk(ref_clk),
    .addr(arr_addr),
    .wr_lanes(arr_lanes),
    .wr_data(st_r.din),
    .rd_data(arr_q)
  );

  assign cmp_eq = (arr_q == st_r.cmp_din);

  always_comb begin
    st_nxt = st_r;
    if (proc_start) begin
      st_nxt.addr_hi = addr[ADDR_W-1:BURST_W];
      st_nxt.op = cs_ok ? CYC_READ : CYC_IDLE;
      st_nxt.lanes = LANES_NONE;
    end else if (ctrl_start) begin
      st_nxt.addr_hi = addr[ADDR_W-1:BURST_W];
      st_nxt.lanes = pin_lanes;
      if (!cs_ok) begin
        st_nxt.op = CYC_IDLE;
      end else if (pin_lanes != LANES_NONE) begin
        st_nxt.op = CYC_WRITE;
      end else begin
        st_nxt.op = CYC_READ;
      end
    end else if (st_r.op != CYC_IDLE) begin
      // burst continues; write controls are re-sampled each cycle
      st_nxt.lanes = pin_lanes;
      st_nxt.op = (pin_lanes != LANES_NONE) ? CYC_WRITE : CYC_READ;
    end
    if (!din_load_en_n && cs_ok) begin
      st_nxt.din = dq_in;
    end
    // data register value that meets the array word next cycle
    st_nxt.cmp_din = st_r.din;
    st_nxt.rd_vld = (st_r.op == CYC_READ);
    if (st_r.rd_vld) begin
      st_nxt.match = cmp_eq;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r.addr_hi <= ADDR_HI_RST;
      st_r.op <= CYC_IDLE;
      st_r.lanes <= LANES_NONE;
      st_r.din <= DATA_RST;
      st_r.cmp_din <= DATA_RST;
      st_r.rd_vld <= 1'b0;
      st_r.match <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // enables are asynchronous by design, so they bypass the clock
  assign dq_out = arr_q;
  assign dq_oe = st_r.rd_vld && !data_out_drive_n;
  assign match_out = st_r.match;
  assign match_oe = !compare_out_drive_n;

  // checks
  logic past_ok_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      past_ok_r <= 1'b0;
    end else begin
      past_ok_r <= 1'b1;
    end
  end

  din_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    past_ok_r && (din_load_en_n || !cs_ok) |=> $stable(st_r.din))
    else $error("data register changed without load");

  din_load_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !din_load_en_n && cs_ok |=> st_r.din == $past(dq_in))
    else $error("data register missed a load");

  match_pipe_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    st_r.rd_vld |=> match_out == $past(cmp_eq))
    else $error("match not registered from compare");

  match_keep_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    past_ok_r && !st_r.rd_vld |=> $stable(match_out))
    else $error("match changed without a read");

  data_gate_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    data_out_drive_n |-> !dq_oe)
    else $error("data driven while output enable high");

  deselect_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    ctrl_start && !cs_ok |=> st_r.op == CYC_IDLE ##1 !dq_oe)
    else $error("deselect slower than one cycle");

  proc_gate_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !addr_load && st_r.op == CYC_IDLE |=> st_r.op == CYC_IDLE)
    else $error("access began without a strobe");

  proc_read_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    proc_start && cs_ok |=> st_r.op == CYC_READ
      && st_r.addr_hi == $past(addr[ADDR_W-1:BURST_W]))
    else $error("processor strobe did not start a read");

  wait_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !addr_load && burst_advance_n && st_r.op != CYC_IDLE
      |=> $stable(arr_addr))
    else $error("burst moved during a wait cycle");

  linear_step_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    burst_step && !burst_mode
      |=> burst_lo == BURST_W'($past(burst_lo) + BURST_STEP))
    else $error("linear burst did not increment");

  global_write_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    ctrl_start && cs_ok && !all_bytes_write_n
      |=> st_r.op == CYC_WRITE && st_r.lanes == LANES_ALL)
    else $error("global write missed a lane");

  gate_off_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    ctrl_start && cs_ok && all_bytes_write_n && byte_write_gate_n
      |=> st_r.op == CYC_READ)
    else $error("byte enable wrote with gate high");

  low_lane_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    st_r.op == CYC_WRITE |-> arr_lanes[LOW_LANE] ==
      $past(!all_bytes_write_n || (!byte_write_gate_n
      && !low_byte_wr_n)))
    else $error("low lane enable wrong");

  // burst start must come from the strobed address, not the old count
  burst_load_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    addr_load |=> burst_lo == $past(addr[BURST_W-1:0]))
    else $error("burst did not start at strobed address");

  // write lanes land on the edge after the controls were taken
  write_land_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    ctrl_start && cs_ok && pin_lanes != LANES_NONE
      |=> arr_lanes == $past(pin_lanes))
    else $error("write lanes not applied one edge later");

  high_lane_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    st_r.op == CYC_WRITE |-> arr_lanes[HIGH_LANE] ==
      $past(!all_bytes_write_n || (!byte_write_gate_n
      && !high_byte_wr_n)))
    else $error("high lane enable wrong");

  // match pin follows its enable with no clock in between
  match_gate_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    compare_out_drive_n |-> !match_oe)
    else $error("match driven while its enable high");

  desel_cov: cover property (
    @(posedge ref_clk) disable iff (rst)
    ctrl_start && !cs_ok ##1 st_r.op == CYC_IDLE);

  write_cov: cover property (
    @(posedge ref_clk) disable iff (rst)
    st_r.op == CYC_WRITE ##1 st_r.op == CYC_READ);

  hit_cov: cover property (
    @(posedge ref_clk) disable iff (rst)
    st_r.rd_vld && cmp_eq ##1 match_out);

  burst_cov: cover property (
    @(posedge ref_clk) disable iff (rst)
    burst_step [*3]);

  interleave_cov: cover property (
    @(posedge ref_clk) disable iff (rst)
    burst_step && burst_mode);

endmodule

// file: dv/cache_host.sv
// Purpose: host model driving the tag memory pins and the shared data bus
// Assumes: tasks are entered and left 1 ns after a rising edge
// Notes: a released bus shows the inverse of its last level
module cache_host
  import tag_ram_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // device side of the bus
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe,
  // host pins
  output logic [ADDR_W-1:0] addr,
  output logic proc_addr_strobe_n,
  output logic ctrl_addr_strobe_n,
  output logic burst_advance_n,
  output chip_sel_t cs,
  output wr_ctl_t wc,
  output logic din_load_en_n,
  output logic [DATA_W-1:0] dq_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DATA_W-1:0] hd;
  logic [DATA_W-1:0] last;
  logic hd_en;

  // no keeper: a floating bus toggles, so stale data never passes a test
  assign dq_in = dq_oe ? dq_out : (hd_en ? hd : ~last);
  always @(posedge ref_clk) begin
    last <= dq_in;
  end

  initial begin
    last = 18'h00000;
    addr = 18'h00000;
    burst_advance_n = 1'b1;
    hd = 18'h00000;
    hd_en = 1'b0;
    release_pins();
  end

  task automatic release_pins();
    proc_addr_strobe_n = 1'b1;
    ctrl_addr_strobe_n = 1'b1;
    cs = 3'h1;
    wc = 4'hf;
    din_load_en_n = 1'b1;
    hd_en = 1'b0;
  endtask

  // every access starts with one strobed cycle
  task automatic issue(input logic proc, input logic [ADDR_W-1:0] a,
      input chip_sel_t c, input wr_ctl_t w, input logic ld,
      input logic [DATA_W-1:0] d);
    proc_addr_strobe_n = !proc;
    ctrl_addr_strobe_n = proc;
    addr = a;
    cs = c;
    wc = w;
    din_load_en_n = !ld;
    hd = d;
    hd_en = ld;
    @(posedge ref_clk);
    #1;
    release_pins();
  endtask

  task automatic desel();
    issue(1'b0, addr, 3'h0, 4'hf, 1'b0, hd);
  endtask

  task automatic set_step(input logic v);
    burst_advance_n = v;
  endtask
endmodule

// file: dv/tb_tag_ram.sv
// Purpose: self-checking bench for the pipelined tag memory
// Assumes: pins change 1 ns after the rising edge
// Notes: every access ends with a deselect to free the bus
module tb_tag_ram import tag_ram_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [ADDR_W-1:0] A0 = 18'h00010;
  localparam logic [ADDR_W-1:0] A1 = 18'h00020;
  logic ref_clk, rst, burst_mode, oe_n, match_en_n;
  logic [ADDR_W-1:0] addr;
  logic ps_n, cs_strb_n, step_n, ld_n;
  chip_sel_t cs;
  wr_ctl_t wc;
  logic [DATA_W-1:0] dq_in, dq_out;
  logic dq_oe, match_out, match_oe;
  int n_errors, comparisons, cycles;

  cache_host host (.ref_clk(ref_clk), .dq_out(dq_out), .dq_oe(dq_oe),
    .addr(addr), .proc_addr_strobe_n(ps_n), .ctrl_addr_strobe_n(cs_strb_n),
    .burst_advance_n(step_n), .cs(cs), .wc(wc), .din_load_en_n(ld_n),
    .dq_in(dq_in));

  tag_ram dut (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .proc_addr_strobe_n(ps_n), .ctrl_addr_strobe_n(cs_strb_n),
    .burst_advance_n(step_n), .burst_mode(burst_mode),
    .chip_en_n(cs.chip_en_n), .chip_sel_depth_n(cs.chip_sel_depth_n),
    .chip_sel_depth(cs.chip_sel_depth), .low_byte_wr_n(wc.low_byte_wr_n),
    .high_byte_wr_n(wc.high_byte_wr_n),
    .byte_write_gate_n(wc.byte_write_gate_n),
    .all_bytes_write_n(wc.all_bytes_write_n), .din_load_en_n(ld_n),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .data_out_drive_n(oe_n), .match_out(match_out), .match_oe(match_oe),
    .compare_out_drive_n(match_en_n));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input logic [DATA_W-1:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // hang guard, the whole run needs under a hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      input wr_ctl_t w);
    host.issue(1'b0, a, 3'h1, w, 1'b1, d);
    host.desel();
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic ld,
      input logic [DATA_W-1:0] t, exp, input logic m);
    host.issue(1'b1, a, 3'h1, 4'hf, ld, t);
    tick();
    chk(dq_out, exp);
    chk(dq_oe, 1'b1);
    host.desel();
    chk(match_out, m);
    tick();
    chk(dq_oe, 1'b0);
  endtask

  task automatic s_write_read();
    wr(A0, 18'h2a5c3, 4'h7);
    rd(A0, 1'b1, 18'h2a5c3, 18'h2a5c3, 1'b1);
    rd(A0, 1'b1, 18'h2a5c2, 18'h2a5c3, 1'b0);
  endtask

  task automatic s_bytes();
    wr(A1, 18'h00000, 4'h7);
    wr(A1, 18'h3ffff, 4'ha);
    rd(A1, 1'b1, 18'h001ff, 18'h001ff, 1'b1);
    wr(A1, 18'h3ffff, 4'h9);
    rd(A1, 1'b1, 18'h3ffff, 18'h3ffff, 1'b1);
    wr(A1, 18'h00000, 4'hc);
    rd(A1, 1'b1, 18'h3ffff, 18'h3ffff, 1'b1);
  endtask

  task automatic s_burst();
    int k[6];
    logic [1:0] lo;
    k = '{0, 1, 2, 2, 3, 0};
    for (int j = 0; j < 4; j++) begin
      wr(18'(18'h00040 + j), 18'(18'h00040 + j), 4'h7);
    end
    for (int m = 0; m < 2; m++) begin
      burst_mode = m[0];
      host.set_step(1'b0);
      host.issue(1'b1, 18'h00041, 3'h1, 4'hf, 1'b0, 18'h00000);
      for (int i = 0; i < 6; i++) begin
        host.set_step(i == 2);
        tick();
        lo = m[0] ? (2'h1 ^ 2'(k[i])) : (2'h1 + 2'(k[i]));
        chk(dq_out, {16'h0010, lo});
      end
      host.set_step(1'b1);
      host.desel();
      tick();
    end
  endtask

  task automatic s_desel();
    rd(A0, 1'b1, 18'h2a5c3, 18'h2a5c3, 1'b1);
    for (int j = 0; j < 3; j++) begin
      host.issue(1'b1, A0, 3'(3'h1 ^ (3'h1 << j)), 4'hf, 1'b1, 18'h00000);
      tick();
      chk(dq_oe, 1'b0);
      rd(A0, 1'b0, 18'h00000, 18'h2a5c3, 1'b1);
    end
  endtask

  task automatic s_oe();
    host.issue(1'b1, A0, 3'h1, 4'hf, 1'b0, 18'h00000);
    tick();
    host.desel();
    oe_n = 1'b1;
    #1;
    chk(dq_oe, 1'b0);
    oe_n = 1'b0;
    #1;
    chk(dq_oe, 1'b1);
    match_en_n = 1'b1;
    #1;
    chk(match_oe, 1'b0);
    match_en_n = 1'b0;
    #1;
    chk(match_oe, 1'b1);
    tick();
  endtask

  initial begin
    rst = 1'b1;
    burst_mode = 1'b0;
    oe_n = 1'b0;
    match_en_n = 1'b0;
    repeat (16) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    s_write_read();
    s_bytes();
    s_burst();
    s_desel();
    s_oe();
    close_out();
  end
endmodule
